// ==== owc_timer.sv ====
// Shared constants, carrier types and the pulse timer of the command
// sequencer of a serial to single wire bus bridge.
// Assumes one 10 MHz clock and an active low asynchronous reset.
package owc_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TW = 23;
   // Pulse durations, as times and as derived cycle counts
   localparam int unsigned PROG_LONG_US = 512;
   localparam int unsigned PROG_DFLT_US = 16;
   localparam int unsigned SPU_LONG_MS = 524;
   localparam int unsigned SPU_DFLT_MS = 16;
   localparam logic [TW-1:0] PROG_LONG_CYC =
      TW'(PROG_LONG_US * (CLK_HZ / 1_000_000));
   localparam logic [TW-1:0] PROG_DFLT_CYC =
      TW'(PROG_DFLT_US * (CLK_HZ / 1_000_000));
   localparam logic [TW-1:0] SPU_LONG_CYC =
      TW'(SPU_LONG_MS * (CLK_HZ / 1_000));
   localparam logic [TW-1:0] SPU_DFLT_CYC =
      TW'(SPU_DFLT_MS * (CLK_HZ / 1_000));
   // Host codes and answers
   localparam logic [7:0] CMD_PROG_CFG = 8'h29;
   localparam logic [7:0] RESP_PROG_CFG = 8'h28;
   localparam logic [7:0] CMD_SPU_CFG = 8'h39;
   localparam logic [7:0] RESP_SPU_CFG = 8'h38;
   localparam logic [7:0] CMD_DATA_MODE = 8'hE1;
   localparam logic [7:0] CMD_CMD_MODE = 8'hE3;
   localparam logic [7:0] CMD_PROG = 8'hFD;
   localparam logic [7:0] CMD_ARM = 8'hEF;
   localparam logic [7:0] CMD_DISARM = 8'hED;
   localparam logic [7:0] CMD_TERM = 8'hF1;
   localparam logic [7:0] CMD_RESET = 8'hC1;
   localparam logic [7:0] RESP_PRESENCE = 8'hCD;
   localparam logic [7:0] RESP_ALARM = 8'hED;
   localparam logic [7:0] PULSE_MASK = 8'hFC;
   localparam logic [7:0] RESP_DATA_PULSE = 8'hEC;
   // Serial rate code bit that selects inverted line polarity
   localparam int unsigned INV_BIT = 2;
   localparam logic LINE_IDLE = 1'b1;
   typedef enum logic [1:0]
   {
      OWC_BUS_RESET = 2'h1,
      OWC_BUS_BYTE = 2'h2
   } owc_bus_kind_type;
   typedef struct packed
   {
      owc_bus_kind_type kind;
      logic [7:0] data;
   } owc_bus_cmd_type;
endpackage : owc_pkg

`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module owc_timer
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Control
   input wire logic load,
   input wire logic [owc_pkg::TW-1:0] load_val,
   input wire logic stop,
   // Status
   output logic expired
);
   logic [owc_pkg::TW-1:0] cnt;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         cnt <= '0;
      else if (load)
         cnt <= load_val;
      else if (stop)
         cnt <= '0;
      else if (cnt != '0)
         cnt <= cnt - 1'b1;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         expired <= 1'b0;
      else
         expired <= (cnt == 23'h000001) && !load && !stop;
   end
endmodule : owc_timer

// ==== owc_cmd_seq.sv ====
// Byte command interpreter of a serial to single wire bus bridge.
// Assumes a host UART byte stream on one side and a bus engine that
// runs resets and byte slots and answers with a one-cycle done pulse.
`timescale 1ns/100ps

module owc_cmd_seq #(
   parameter logic [owc_pkg::TW-1:0] PROG_LONG_CYC = owc_pkg::PROG_LONG_CYC,
   parameter logic [owc_pkg::TW-1:0] PROG_DFLT_CYC = owc_pkg::PROG_DFLT_CYC,
   parameter logic [owc_pkg::TW-1:0] SPU_LONG_CYC = owc_pkg::SPU_LONG_CYC,
   parameter logic [owc_pkg::TW-1:0] SPU_DFLT_CYC = owc_pkg::SPU_DFLT_CYC
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Host bytes in
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   // Answers to host
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   // Serial lines and rate code
   input wire logic ser_rx_pin,
   output logic uart_rx_line,
   input wire logic uart_tx_line,
   output logic ser_tx_pin,
   input wire logic [2:0] baud_code,
   // Bus engine
   output logic bus_req,
   output owc_pkg::owc_bus_cmd_type bus_cmd,
   input wire logic bus_done,
   input wire logic [7:0] bus_rd_byte,
   input wire logic bus_alarm,
   // Power and status
   output logic spu_on,
   output logic vpp_on,
   output logic data_mode,
   output logic armed
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h1,
      ST_BUS = 3'h2,
      ST_PULSE = 3'h4
   } owc_state_type;

   owc_state_type state;
   logic [7:0] cur_cmd;
   logic [7:0] pulse_resp;
   logic buf_full;
   logic [7:0] buf_byte;
   logic prog_long;
   logic spu_long;
   logic ser_rx_s1, ser_rx_s2;
   logic [2:0] baud_s1, baud_s2;
   logic consume, take_cmd, take_data, f1_hit, pulse_end, bus_fin;
   logic start_vpp, start_spu, tmr_load, tmr_expired, resp_evt;
   logic [7:0] resp_val;
   logic [owc_pkg::TW-1:0] tmr_val;

   function automatic logic [7:0] pulse_answer(input logic [7:0] code);
      pulse_answer = code & owc_pkg::PULSE_MASK;
   endfunction : pulse_answer

   ////////////////////////////////////////////////////////////////////////
   // Decode of the byte leaving the buffer
   always_comb
   begin
      consume = buf_full && (state == ST_IDLE);
      take_cmd = consume && !data_mode;
      take_data = consume && data_mode;
      // Termination only counts for command mode pulses
      f1_hit = buf_full && (state == ST_PULSE) && !data_mode &&
               (buf_byte == owc_pkg::CMD_TERM);
      pulse_end = (state == ST_PULSE) && (tmr_expired || f1_hit);
      bus_fin = (state == ST_BUS) && bus_done;
      start_vpp = take_cmd && (buf_byte == owc_pkg::CMD_PROG);
      start_spu = (take_cmd && ((buf_byte == owc_pkg::CMD_ARM) ||
                  (buf_byte == owc_pkg::CMD_DISARM))) ||
                  (bus_fin && data_mode && armed);
      tmr_load = start_vpp || start_spu;
      if (start_vpp)
         tmr_val = prog_long ? PROG_LONG_CYC : PROG_DFLT_CYC;
      else
         tmr_val = spu_long ? SPU_LONG_CYC : SPU_DFLT_CYC;
      resp_evt = 1'b0;
      resp_val = 8'h00;
      if (take_cmd && (buf_byte == owc_pkg::CMD_PROG_CFG))
      begin
         resp_evt = 1'b1;
         resp_val = owc_pkg::RESP_PROG_CFG;
      end
      else if (take_cmd && (buf_byte == owc_pkg::CMD_SPU_CFG))
      begin
         resp_evt = 1'b1;
         resp_val = owc_pkg::RESP_SPU_CFG;
      end
      else if (bus_fin && (cur_cmd == owc_pkg::CMD_RESET) && !data_mode)
      begin
         resp_evt = 1'b1;
         resp_val = bus_alarm ? owc_pkg::RESP_ALARM : owc_pkg::RESP_PRESENCE;
      end
      else if (bus_fin)
      begin
         resp_evt = 1'b1;
         resp_val = bus_rd_byte;
      end
      else if (pulse_end)
      begin
         resp_evt = 1'b1;
         resp_val = pulse_resp;
      end
   end

   owc_timer u_timer
   (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .load(tmr_load),
      .load_val(tmr_val),
      .stop(f1_hit),
      .expired(tmr_expired)
   );

   ////////////////////////////////////////////////////////////////////////
   // Single byte holding buffer; a byte arriving while full is lost unless the held byte leaves in that cycle
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         buf_full <= 1'b0;
      else if (rx_valid && (!buf_full || consume || f1_hit))
         buf_full <= 1'b1;
      else if (consume || f1_hit)
         buf_full <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         buf_byte <= 8'h00;
      else if (rx_valid && (!buf_full || consume || f1_hit))
         buf_byte <= rx_byte;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencing
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         cur_cmd <= 8'h00;
         pulse_resp <= 8'h00;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               cur_cmd <= buf_byte;
               if (take_data && (buf_byte != owc_pkg::CMD_CMD_MODE))
                  state <= ST_BUS;
               else if (take_cmd && (buf_byte == owc_pkg::CMD_RESET))
                  state <= ST_BUS;
               else if (start_vpp || start_spu)
               begin
                  state <= ST_PULSE;
                  pulse_resp <= pulse_answer(buf_byte);
               end
            end
            ST_BUS:
            begin
               if (bus_fin && start_spu)
               begin
                  state <= ST_PULSE;
                  pulse_resp <= owc_pkg::RESP_DATA_PULSE;
               end
               else if (bus_fin)
                  state <= ST_IDLE;
            end
            ST_PULSE:
            begin
               if (pulse_end)
                  state <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode and configuration flags
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         data_mode <= 1'b0;
         armed <= 1'b0;
         prog_long <= 1'b0;
         spu_long <= 1'b0;
      end
      else
      begin
         if (take_cmd && (buf_byte == owc_pkg::CMD_DATA_MODE))
            data_mode <= 1'b1;
         if (take_data && (buf_byte == owc_pkg::CMD_CMD_MODE))
            data_mode <= 1'b0;
         if (take_cmd && (buf_byte == owc_pkg::CMD_ARM))
            armed <= 1'b1;
         if (take_cmd && (buf_byte == owc_pkg::CMD_DISARM))
            armed <= 1'b0;
         if (take_cmd && (buf_byte == owc_pkg::CMD_PROG_CFG))
            prog_long <= 1'b1;
         if (take_cmd && (buf_byte == owc_pkg::CMD_SPU_CFG))
            spu_long <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus requests and drivers
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_req <= 1'b0;
         bus_cmd <= '{kind: owc_pkg::OWC_BUS_BYTE, data: 8'h00};
      end
      else
      begin
         bus_req <= (take_data && (buf_byte != owc_pkg::CMD_CMD_MODE)) ||
                    (take_cmd && (buf_byte == owc_pkg::CMD_RESET));
         if (consume)
         begin
            bus_cmd.kind <= data_mode ? owc_pkg::OWC_BUS_BYTE :
                            owc_pkg::OWC_BUS_RESET;
            bus_cmd.data <= buf_byte;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         vpp_on <= 1'b0;
         spu_on <= 1'b0;
      end
      else if (pulse_end)
      begin
         vpp_on <= 1'b0;
         spu_on <= 1'b0;
      end
      else
      begin
         if (start_vpp)
            vpp_on <= 1'b1;
         if (start_spu)
            spu_on <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer holding register; a new answer wins over the handshake
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_valid <= 1'b0;
         tx_byte <= 8'h00;
      end
      else if (resp_evt)
      begin
         tx_valid <= 1'b1;
         tx_byte <= resp_val;
      end
      else if (tx_ready)
         tx_valid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Line polarity; the rate code is a slow strap, synchronised anyway
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ser_rx_s1 <= owc_pkg::LINE_IDLE;
         ser_rx_s2 <= owc_pkg::LINE_IDLE;
         baud_s1 <= 3'h0;
         baud_s2 <= 3'h0;
         uart_rx_line <= owc_pkg::LINE_IDLE;
         ser_tx_pin <= owc_pkg::LINE_IDLE;
      end
      else
      begin
         ser_rx_s1 <= ser_rx_pin;
         ser_rx_s2 <= ser_rx_s1;
         baud_s1 <= baud_code;
         baud_s2 <= baud_s1;
         uart_rx_line <= ser_rx_s2 ^ baud_s2[owc_pkg::INV_BIT];
         ser_tx_pin <= uart_tx_line ^ baud_s2[owc_pkg::INV_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   a_prog_cfg_ack: assert property (take_cmd &&
      buf_byte == owc_pkg::CMD_PROG_CFG |=> tx_valid &&
      tx_byte == owc_pkg::RESP_PROG_CFG && prog_long)
      else $error("program pulse setting not acknowledged");
   a_spu_cfg_ack: assert property (take_cmd &&
      buf_byte == owc_pkg::CMD_SPU_CFG |=> tx_valid &&
      tx_byte == owc_pkg::RESP_SPU_CFG && spu_long)
      else $error("pullup setting not acknowledged");
   a_armed_pulse_resp: assert property ($fell(spu_on) && data_mode |->
      tx_valid && tx_byte == owc_pkg::RESP_DATA_PULSE)
      else $error("missing pulse answer after armed pullup");
   a_rx_polarity: assert property ($stable(baud_s2) |->
      uart_rx_line == ($past(ser_rx_pin, 3) ^ baud_s2[owc_pkg::INV_BIT]))
      else $error("receive polarity wrong");
   a_term_ends_pulse: assert property (f1_hit |=> !vpp_on && !spu_on &&
      tx_valid && tx_byte == $past(pulse_resp) && state == ST_IDLE)
      else $error("termination did not end pulse");
   a_spu_start: assert property (bus_fin && data_mode && armed |=>
      spu_on && tx_valid && tx_byte == $past(bus_rd_byte))
      else $error("armed pullup not started with data answer");
   a_buffer_hold: assert property (rx_valid && !buf_full |=>
      buf_full && buf_byte == $past(rx_byte))
      else $error("host byte not held");
   a_reset_answer: assert property (bus_fin && !data_mode |=> tx_valid &&
      tx_byte == ($past(bus_alarm) ? owc_pkg::RESP_ALARM :
      owc_pkg::RESP_PRESENCE))
      else $error("reset answer wrong");
   a_silent_codes: assert property (consume && !tx_valid &&
      (buf_byte == owc_pkg::CMD_DATA_MODE ||
      buf_byte == owc_pkg::CMD_CMD_MODE) |=> !tx_valid)
      else $error("mode switch produced an answer");
   a_vpp_source: assert property ($rose(vpp_on) |-> $past(take_cmd) &&
      $past(buf_byte) == owc_pkg::CMD_PROG && !spu_on)
      else $error("program pulse without its code");

   c_armed_data: cover property ($fell(spu_on) && data_mode);
   c_term: cover property (f1_hit);
   c_reset: cover property (bus_fin && !data_mode && bus_alarm);
   c_prog: cover property ($fell(vpp_on) && prog_long);
endmodule : owc_cmd_seq

// ==== owc_bus_model.sv ====
// Bus engine stand-in: answers each request after a set delay.
// Assumes the sequencer's bus_req pulse and bus_cmd carrier.
`timescale 1ns/100ps

module owc_bus_model
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Sequencer side
   input wire logic bus_req,
   input wire owc_pkg::owc_bus_cmd_type bus_cmd,
   output logic bus_done,
   output logic [7:0] bus_rd_byte,
   output logic bus_alarm,
   // Scenario control
   input wire logic [7:0] delay,
   input wire logic [7:0] rd_mask,
   input wire logic alarm_en
);
   logic busy;
   logic [7:0] cnt;
   owc_pkg::owc_bus_cmd_type cmd;

   // Outside a done pulse the read lines toggle so stale data never matches
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy <= 1'b0;
         cnt <= 8'h00;
         cmd <= '0;
         bus_done <= 1'b0;
         bus_rd_byte <= 8'h00;
         bus_alarm <= 1'b0;
      end
      else
      begin
         bus_done <= 1'b0;
         bus_rd_byte <= ~bus_rd_byte;
         bus_alarm <= ~bus_alarm;
         if (bus_req)
         begin
            busy <= 1'b1;
            cnt <= delay;
            cmd <= bus_cmd;
         end
         else if (busy && cnt != 8'h00)
            cnt <= cnt - 8'h01;
         else if (busy)
         begin
            busy <= 1'b0;
            bus_done <= 1'b1;
            bus_rd_byte <= cmd.data ^ rd_mask;
            bus_alarm <= alarm_en && (cmd.kind == owc_pkg::OWC_BUS_RESET);
         end
      end
   end
endmodule : owc_bus_model

// ==== testbench.sv ====
// Self-checking bench for the byte command sequencer.
// Assumes short pulse counts and the bus engine model.
`timescale 1ns/100ps

module testbench;
   localparam int PL = 20;
   localparam int PD = 10;
   localparam int SL = 40;
   logic ref_clk, nrst, rx_valid, tx_valid, tx_ready;
   logic [7:0] rx_byte, tx_byte, bus_rd_byte, delay, rd_mask;
   logic ser_rx_pin, uart_rx_line, uart_tx_line, ser_tx_pin;
   logic [2:0] baud_code;
   logic bus_req, bus_done, bus_alarm, alarm_en;
   logic spu_on, vpp_on, data_mode, armed;
   owc_pkg::owc_bus_cmd_type bus_cmd;
   int err_count, checked, n;

   always #50 ref_clk = ~ref_clk;

   owc_cmd_seq #(.PROG_LONG_CYC(23'(PL)), .PROG_DFLT_CYC(23'(PD)),
      .SPU_LONG_CYC(23'(SL)), .SPU_DFLT_CYC(23'h00000F)) owc_cmd_seq_i (
      .ref_clk(ref_clk), .nrst(nrst), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_ready(tx_ready), .ser_rx_pin(ser_rx_pin),
      .uart_rx_line(uart_rx_line), .uart_tx_line(uart_tx_line),
      .ser_tx_pin(ser_tx_pin), .baud_code(baud_code),
      .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_done(bus_done),
      .bus_rd_byte(bus_rd_byte), .bus_alarm(bus_alarm),
      .spu_on(spu_on), .vpp_on(vpp_on), .data_mode(data_mode),
      .armed(armed));

   owc_bus_model owc_bus_model_i (.ref_clk(ref_clk), .nrst(nrst),
      .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_done(bus_done),
      .bus_rd_byte(bus_rd_byte), .bus_alarm(bus_alarm),
      .delay(delay), .rd_mask(rd_mask), .alarm_en(alarm_en));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic send(input logic [7:0] b);
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      @(posedge ref_clk);
      // The idle cycle between bytes keeps each rx_valid strobe one cycle long
      rx_valid <= 1'b0;
   endtask : send

   // Answers stand one cycle with tx_ready held, so poll every negedge
   task automatic get_ans(input logic [7:0] exp);
      int i;
      for (i = 0; i < 300 && tx_valid !== 1'b1; i++)
         @(negedge ref_clk);
      // A missing answer must not pass on a stale byte
      check("answer_valid", tx_valid, 1'b1);
      check("answer", tx_byte, exp);
      @(negedge ref_clk);
   endtask : get_ans

   task automatic quiet(input logic [7:0] b);
      int c;
      c = 0;
      send(b);
      repeat (12)
      begin
         @(negedge ref_clk);
         if (tx_valid !== 1'b0)
            c++;
      end
      check("silent", 8'(c), 8'h00);
   endtask : quiet

   // Counts the cycles a pulse output stays high; the answer lands as it ends
   task automatic measure(input bit spu, input logic [7:0] exp);
      int i;
      n = 0;
      for (i = 0; i < 30 && (spu ? spu_on : vpp_on) !== 1'b1; i++)
         @(negedge ref_clk);
      while ((spu ? spu_on : vpp_on) === 1'b1 && n < 300)
      begin
         n++;
         @(negedge ref_clk);
      end
      check("pulse_answer", tx_valid ? tx_byte : 8'h00, exp);
   endtask : measure

   ////////////////////////////////////////////////////////////////////////
   task automatic test_polarity;
      int c;
      for (c = 0; c < 8; c++)
      begin
         @(posedge ref_clk);
         baud_code <= 3'(c);
         ser_rx_pin <= c[0];
         uart_tx_line <= c[1];
         // Code and pin pass two stages before the output flop
         repeat (4) @(negedge ref_clk);
         check("rx_line", uart_rx_line, c[0] ^ c[2]);
         check("tx_pin", ser_tx_pin, c[1] ^ c[2]);
      end
      @(posedge ref_clk);
      baud_code <= 3'b000;
      ser_rx_pin <= 1'b1;
      uart_tx_line <= 1'b1;
   endtask : test_polarity

   task automatic test_reset;
      send(8'hC1);
      get_ans(8'hCD);
      alarm_en <= 1'b1;
      delay <= 8'd40;
      send(8'hC1);
      get_ans(8'hED);
      alarm_en <= 1'b0;
      delay <= 8'd3;
   endtask : test_reset

   task automatic test_prog;
      send(8'hFD);
      measure(0, 8'hFC);
      check("vpp_dflt", 8'(n >= PD && n <= PD + 2), 8'h01);
      send(8'h29);
      get_ans(8'h28);
      // Host byte loop: data, two check reads, E3, FD, E1, read back
      quiet(8'hE1);
      check("data_mode", data_mode, 1'b1);
      send(8'hA5);
      get_ans(8'hA5);
      rd_mask <= 8'h3C;
      send(8'hFF);
      get_ans(8'hC3);
      send(8'hFF);
      get_ans(8'hC3);
      rd_mask <= 8'h00;
      quiet(8'hE3);
      send(8'hFD);
      measure(0, 8'hFC);
      check("vpp_long", 8'(n >= PL && n <= PL + 2), 8'h01);
      quiet(8'hE1);
      send(8'hFF);
      get_ans(8'hFF);
      quiet(8'hE3);
   endtask : test_prog

   task automatic test_term;
      send(8'hFD);
      repeat (3) @(posedge ref_clk);
      send(8'hF1);
      measure(0, 8'hFC);
      check("vpp_cut", 8'(n < PL - 4), 8'h01);
      quiet(8'hF1);
   endtask : test_term

   task automatic test_armed;
      send(8'h39);
      get_ans(8'h38);
      send(8'hEF);
      send(8'hF1);
      measure(1, 8'hEC);
      check("armed", armed, 1'b1);
      quiet(8'hE1);
      send(8'h44);
      get_ans(8'h44);
      check("spu_start", spu_on, 1'b1);
      measure(1, 8'hEC);
      check("spu_long", 8'(n >= SL - 1 && n <= SL + 3), 8'h01);
      quiet(8'hE3);
      send(8'hED);
      send(8'hF1);
      measure(1, 8'hEC);
      check("disarmed", armed, 1'b0);
   endtask : test_armed

   task automatic test_buffer;
      delay <= 8'd10;
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_byte <= 8'hC1;
      @(posedge ref_clk);
      rx_byte <= 8'h29;
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      get_ans(8'hCD);
      get_ans(8'h28);
   endtask : test_buffer

   // An answer must stand until the consumer takes it
   task automatic test_hold;
      @(posedge ref_clk);
      tx_ready <= 1'b0;
      send(8'h29);
      repeat (6) @(negedge ref_clk);
      check("held_valid", tx_valid, 1'b1);
      check("held_byte", tx_byte, 8'h28);
      @(posedge ref_clk);
      tx_ready <= 1'b1;
      repeat (2) @(negedge ref_clk);
      check("released", tx_valid, 1'b0);
   endtask : test_hold

   // Reset in mid-run returns to command mode with no answer and no pullup standing
   task automatic test_mid_reset;
      quiet(8'hE1);
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(negedge ref_clk);
      check("mid_rst_mode", data_mode, 1'b0);
      check("mid_rst_tx", tx_valid, 1'b0);
      check("mid_rst_spu", spu_on, 1'b0);
      send(8'h29);
      get_ans(8'h28);
   endtask : test_mid_reset

   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b1;
      ser_rx_pin = 1'b1;
      uart_tx_line = 1'b1;
      baud_code = 3'b000;
      delay = 8'd3;
      rd_mask = 8'h00;
      alarm_en = 1'b0;
      err_count = 0;
      checked = 0;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      @(negedge ref_clk);
      check("rst_tx_valid", tx_valid, 1'b0);
      check("rst_mode", data_mode, 1'b0);
      check("rst_tx_pin", ser_tx_pin, 1'b1);
      test_polarity;
      test_reset;
      test_prog;
      test_term;
      test_armed;
      test_buffer;
      test_hold;
      test_mid_reset;
      final_report;
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      final_report;
   end
endmodule : testbench
